// ---- pmb_pkg.sv ----
// ****************************************************************
// converter command bank constants
// ****************************************************************
package pmb_pkg;

    // ************************************************************
    // command codes of the bank
    // ************************************************************
    localparam int NUM_REGS = 24;                 // entries in the bank
    localparam logic [7:0] CODE_SETPOINT = 8'h21; // output set point word
    localparam logic [7:0] CODE_CEILING = 8'h24;  // read-only ceiling word
    localparam logic [7:0] CODE_SRC_SEL = 8'hd1;  // set-point source select byte

    // index of each entry that the logic looks at by name
    localparam int IDX_SETPOINT = 0;   // output set point
    localparam int IDX_CEILING = 1;    // output ceiling
    localparam int IDX_OV_ACT = 7;     // output over-voltage action
    localparam int IDX_OC_ACT = 8;     // output over-current action
    localparam int IDX_OT_ACT = 10;    // over-temperature action
    localparam int IDX_VIN_OV_ACT = 13; // input over-voltage action
    localparam int IDX_VIN_UV_ACT = 17; // input under-voltage action
    localparam int IDX_RISE = 21;      // turn-on ramp time
    localparam int IDX_SRC_SEL = 23;   // set-point source select

    // code per entry, in bank order
    localparam logic [7:0] REG_CODE [NUM_REGS] = '{
        8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h35, 8'h36, 8'h41,
        8'h47, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h56, 8'h57, 8'h58,
        8'h59, 8'h5a, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h64, 8'hd1};

    // reset value per entry
    localparam logic [15:0] REG_RST [NUM_REGS] = '{
        16'h0000, 16'h7800, 16'h7800, 16'h0000, 16'h0000, 16'hf813, 16'h0008, 16'h00bf,
        16'h00ff, 16'h007d, 16'h00c0, 16'h0078, 16'h0042, 16'h00bf, 16'h0042, 16'h000a,
        16'h0009, 16'h0000, 16'h0800, 16'h0600, 16'h000a, 16'h00c8, 16'h0000, 16'h0000};

    // writable bits per entry; all zero marks a read-only entry
    localparam logic [15:0] REG_WMASK [NUM_REGS] = '{
        16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff,
        16'h00ff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff,
        16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0001};

    // accepted response codes in bits 7:6, one bit per code value
    localparam logic [3:0] REG_CODE_OK [NUM_REGS] = '{
        4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h4,
        4'h8, 4'hf, 4'h8, 4'hf, 4'hf, 4'hc, 4'hf, 4'hf,
        4'hf, 4'h5, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int ACT_HI = 7;        // response code field top bit
    localparam int ACT_LO = 6;        // response code field low bit
    localparam int SRC_SEL_BIT = 0;   // source select bit
    localparam logic SRC_CMD = 1'b0;  // take the commanded value
    localparam int RAMP_NUM_W = 26;   // width of mantissa times set point
    localparam int SP_W = 16;         // output voltage word width

    // general linear word: 5-bit exponent over 11-bit mantissa
    typedef struct packed {
        logic [4:0] exp;   // two's complement exponent
        logic [10:0] mant; // two's complement mantissa
    } pmb_linear_type;

    // one command from the link framer
    typedef struct packed {
        logic valid;        // command present this cycle
        logic write;        // write when set, read when clear
        logic [7:0] code;   // command code
        logic [15:0] wdata; // write data, bytes in the low lane
    } pmb_cmd_type;

    // answer to one command
    typedef struct packed {
        logic valid;        // answer present this cycle
        logic err;          // refused or unmapped
        logic [15:0] rdata; // read data
    } pmb_rsp_type;

endpackage

// ---- pmb_div.sv ----
`timescale 1ns/1ps
// ****************************************************************
// serial restoring divider, one quotient bit per clock
// ****************************************************************
module pmb_div #(
    parameter int NUM_W = 26, // dividend width
    parameter int DEN_W = 16  // divisor width
) (
    input wire logic sys_clk,              // system clock
    input wire logic rst_b,                // async reset, active low
    input wire logic start,                // begin a division
    input wire logic [NUM_W-1:0] num,      // dividend
    input wire logic [DEN_W-1:0] den,      // divisor, nonzero
    output logic busy,                     // division in progress
    output logic done_ff,                  // one-cycle pulse at the end
    output logic [NUM_W-1:0] quot_ff       // quotient
);
    localparam int CNT_W = $clog2(NUM_W + 1); // counter width

    logic [NUM_W-1:0] shf_ff;   // dividend bits still to shift in
    logic [DEN_W:0] rem_ff;     // partial remainder
    logic [CNT_W-1:0] cnt_ff;   // bits left
    logic [DEN_W:0] trial;      // remainder with next bit
    logic [DEN_W:0] diff;       // trial minus divisor
    logic fits;                 // divisor fits into trial

    assign busy = (cnt_ff != '0);
    assign trial = {rem_ff[DEN_W-1:0], shf_ff[NUM_W-1]};
    assign diff = trial - {1'b0, den};
    assign fits = (trial >= {1'b0, den});

    // shift one bit each cycle; a start while busy is ignored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shf_ff <= '0;
            rem_ff <= '0;
            cnt_ff <= '0;
            quot_ff <= '0;
            done_ff <= 1'b0;
        end else if (!busy && start) begin
            shf_ff <= num;
            rem_ff <= '0;
            cnt_ff <= CNT_W'(NUM_W);
            done_ff <= 1'b0;
        end else if (busy) begin
            shf_ff <= {shf_ff[NUM_W-2:0], 1'b0};
            rem_ff <= fits ? diff : trial;
            quot_ff <= {quot_ff[NUM_W-2:0], fits};
            cnt_ff <= cnt_ff - 1'b1;
            done_ff <= (cnt_ff == CNT_W'(1));
        end else begin
            done_ff <= 1'b0;
        end
    end
endmodule

// ---- pmb_bank.sv ----
`timescale 1ns/1ps
// Operation
// - commanded set point applies only when source select 0
// - output over-voltage action accepts code 0b10 only
// - over-current and over-temperature actions accept 0b11 only
// - input over-voltage action accepts 0b11 or 0b10
// - input under-voltage action accepts 0b00, 0b10; resets 0b00
// - ramp time scaled by set point over ceiling
// - output voltage words: unsigned mantissa, exponent minus nine
// - linear words: 5-bit exponent, 11-bit mantissa
// - reserved bits and unsupported codes change nothing
module pmb_bank #(
    parameter logic [15:0] SETPOINT_RST = 16'h0000 // set point after reset
) (
    input wire logic sys_clk,                            // 40 MHz clock
    input wire logic rst_b,                              // async reset, active low
    input wire pmb_pkg::pmb_cmd_type cmd,                // command from the framer
    input wire logic [15:0] ext_setpoint,                // external set point source
    output pmb_pkg::pmb_rsp_type rsp_ff,                 // answer, one cycle later
    output logic [pmb_pkg::NUM_REGS-1:0][15:0] bank_ff,  // all stored values
    output logic [15:0] applied_setpoint_ff,             // set point driving the stage
    output pmb_pkg::pmb_linear_type ramp_time_ff,        // scaled turn-on ramp time
    output logic ramp_valid_ff                           // ramp time is up to date
);
    // ************************************************************
    // decode
    // ************************************************************
    logic [pmb_pkg::NUM_REGS-1:0] hit;        // entry addressed
    logic [pmb_pkg::NUM_REGS-1:0] wr_ok;      // write to entry accepted
    logic [15:0] rd_chain [pmb_pkg::NUM_REGS+1]; // read mux chain
    logic any_hit;                            // some entry addressed
    logic any_wr_ok;                          // a write was accepted
    logic [1:0] wr_act;                       // response code being written

    assign wr_act = cmd.wdata[pmb_pkg::ACT_HI:pmb_pkg::ACT_LO];
    assign rd_chain[0] = 16'h0000;

    // ************************************************************
    // storage, one generated entry per command
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < pmb_pkg::NUM_REGS; gi++) begin : g_ent
            logic [15:0] nxt_val; // masked next value
            assign hit[gi] = (cmd.code == pmb_pkg::REG_CODE[gi]);
            // read-only entries and unsupported response codes are refused
            assign wr_ok[gi] = cmd.valid && cmd.write && hit[gi]
                && (pmb_pkg::REG_WMASK[gi] != 16'h0000)
                && pmb_pkg::REG_CODE_OK[gi][wr_act];
            // bits outside the write mask keep reading as their reset value
            assign nxt_val = (cmd.wdata & pmb_pkg::REG_WMASK[gi])
                | (pmb_pkg::REG_RST[gi] & ~pmb_pkg::REG_WMASK[gi]);
            assign rd_chain[gi+1] = rd_chain[gi] | (hit[gi] ? bank_ff[gi] : 16'h0000);

            // store on accepted write only
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    bank_ff[gi] <= (gi == pmb_pkg::IDX_SETPOINT) ? SETPOINT_RST
                        : pmb_pkg::REG_RST[gi];
                end else if (wr_ok[gi]) begin
                    bank_ff[gi] <= nxt_val;
                end
            end
        end
    endgenerate

    assign any_hit = |hit;
    assign any_wr_ok = |wr_ok;

    // ************************************************************
    // answer
    // ************************************************************
    logic nxt_err; // answer carries a refusal

    // unmapped codes and refused writes both answer with err
    assign nxt_err = !any_hit || (cmd.write && !any_wr_ok);

    // answer registered one cycle after the command
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= cmd.valid;
            rsp_ff.err <= cmd.valid && nxt_err;
            rsp_ff.rdata <= (cmd.valid && !cmd.write) ? rd_chain[pmb_pkg::NUM_REGS]
                : 16'h0000;
        end
    end

    // ************************************************************
    // set point source
    // ************************************************************
    logic src_is_cmd; // commanded value selected

    assign src_is_cmd =
        (bank_ff[pmb_pkg::IDX_SRC_SEL][pmb_pkg::SRC_SEL_BIT] == pmb_pkg::SRC_CMD);

    // both sources share the unsigned, exponent minus nine scale
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            applied_setpoint_ff <= 16'h0000;
        end else begin
            applied_setpoint_ff <= src_is_cmd ? bank_ff[pmb_pkg::IDX_SETPOINT]
                : ext_setpoint;
        end
    end

    // ************************************************************
    // ramp time scaling
    // ************************************************************
    pmb_pkg::pmb_linear_type rise;             // programmed rise time
    logic [9:0] rise_mag;                      // mantissa magnitude, negatives as 0
    logic [pmb_pkg::RAMP_NUM_W-1:0] ramp_num;  // mantissa times set point
    logic [31:0] key_now;                      // inputs of the scaling
    logic [31:0] key_ff;                       // inputs of the last scaling
    logic div_busy;                            // divider running
    logic div_done;                            // divider finished
    logic div_start;                           // launch a scaling
    logic [pmb_pkg::RAMP_NUM_W-1:0] div_quot;  // scaled mantissa
    logic over_ceiling;                        // set point above ceiling

    assign rise = bank_ff[pmb_pkg::IDX_RISE];
    assign rise_mag = rise.mant[10] ? 10'h000 : rise.mant[9:0];
    assign ramp_num = pmb_pkg::RAMP_NUM_W'(rise_mag * applied_setpoint_ff);
    assign key_now = {rise, applied_setpoint_ff};
    assign div_start = (key_now != key_ff) && !div_busy;
    assign over_ceiling = (applied_setpoint_ff > bank_ff[pmb_pkg::IDX_CEILING]);

    // ceiling is a fixed nonzero value, so the divisor never is zero
    pmb_div #(
        .NUM_W(pmb_pkg::RAMP_NUM_W),
        .DEN_W(pmb_pkg::SP_W)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(div_start),
        .num(ramp_num),
        .den(bank_ff[pmb_pkg::IDX_CEILING]),
        .busy(div_busy),
        .done_ff(div_done),
        .quot_ff(div_quot)
    );

    // remember what was scaled; a change during a run relaunches after it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            key_ff <= 32'h0000_0000;
        end else if (div_start) begin
            key_ff <= key_now;
        end
    end

    // publish result with the rise exponent kept; applied set points from either source beyond
    // the ceiling are clamped to the full programmed time
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ramp_time_ff <= '0;
            ramp_valid_ff <= 1'b0;
        end else if (div_done) begin
            ramp_time_ff.exp <= rise.exp;
            ramp_time_ff.mant <= over_ceiling ? {1'b0, rise_mag}
                : {1'b0, div_quot[9:0]};
            ramp_valid_ff <= (key_now == key_ff);
        end else if (div_start) begin
            ramp_valid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    cmd_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        src_is_cmd |=> applied_setpoint_ff == $past(bank_ff[pmb_pkg::IDX_SETPOINT]))
        else $error("commanded set point not applied");
    ext_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !src_is_cmd |=> applied_setpoint_ff == $past(ext_setpoint))
        else $error("external set point not applied");
    ov_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bank_ff[pmb_pkg::IDX_OV_ACT][7:6] == 2'b10)
        else $error("output over-voltage action code illegal");
    oc_ot_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bank_ff[pmb_pkg::IDX_OC_ACT][7:6] == 2'b11 && bank_ff[pmb_pkg::IDX_OT_ACT][7:6] == 2'b11)
        else $error("over-current or over-temperature action code illegal");
    vin_ov_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bank_ff[pmb_pkg::IDX_VIN_OV_ACT][7] == 1'b1)
        else $error("input over-voltage action code illegal");
    vin_uv_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bank_ff[pmb_pkg::IDX_VIN_UV_ACT][6] == 1'b0)
        else $error("input under-voltage action code illegal");
    bad_code_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cmd.valid && cmd.write && cmd.code == 8'h41 && cmd.wdata[7:6] != 2'b10)
        |=> rsp_ff.err && $stable(bank_ff[pmb_pkg::IDX_OV_ACT]))
        else $error("unsupported action write changed state");
    src_reserved_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bank_ff[pmb_pkg::IDX_SRC_SEL][15:1] == 15'h0000)
        else $error("reserved source select bits stored");
    ceiling_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cmd.valid && cmd.write && cmd.code == pmb_pkg::CODE_CEILING)
        |=> rsp_ff.valid && rsp_ff.err && bank_ff[pmb_pkg::IDX_CEILING] == 16'h7800)
        else $error("ceiling write not refused");
    ramp_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        div_start |-> ##[1:30] div_done ##1 ramp_time_ff.mant <= {1'b0, rise_mag})
        else $error("ramp scaling late or above programmed time");
    ramp_exp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        div_done |=> ramp_time_ff.exp == $past(rise.exp))
        else $error("ramp exponent not kept");
endmodule

// ---- pmb_host.sv ----
`timescale 1ns/1ps
// ****************************************************************
// host controller model: issues one whole command at a time
// ****************************************************************
module pmb_host (
    input wire logic sys_clk,              // system clock
    output pmb_pkg::pmb_cmd_type cmd,      // command to the bank
    input wire pmb_pkg::pmb_rsp_type rsp   // answer from the bank
);
    // idle until the first command
    initial begin
        cmd = '0;
    end

    // one transfer: drive after a falling edge, hold over the taking edge,
    // then take the registered answer one cycle later
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                        output pmb_pkg::pmb_rsp_type ans);
        @(negedge sys_clk);
        cmd.valid = 1'b1;
        cmd.write = wr;
        cmd.code = code;
        cmd.wdata = wdata; // words travel whole, 16 bits
        @(negedge sys_clk);
        ans = rsp;
        // released fields show the inverse, so a stale value cannot pass as good
        cmd.valid = 1'b0;
        cmd.write = ~wr;
        cmd.code = ~code;
        cmd.wdata = ~wdata;
    endtask
endmodule

// ---- test_converter_pmbus_command_bank.sv ----
`timescale 1ns/1ps
module test_converter_pmbus_command_bank;
    logic sys_clk; // 40 MHz clock
    logic rst_b; // reset, active low
    logic [15:0] ext_setpoint; // external set point source
    pmb_pkg::pmb_cmd_type cmd; // command from the host model
    pmb_pkg::pmb_rsp_type rsp_ff; // answer from the bank
    logic [pmb_pkg::NUM_REGS-1:0][15:0] bank_ff; // stored values
    logic [15:0] applied_setpoint_ff; // set point to the stage
    pmb_pkg::pmb_linear_type ramp_time_ff; // scaled ramp time
    logic ramp_valid_ff; // ramp time up to date
    pmb_pkg::pmb_rsp_type ans; // last answer taken
    int fails; // mismatches
    int comparisons; // comparisons made
    int cycles; // clock cycles run

    pmb_bank DUT (.sys_clk(sys_clk), .rst_b(rst_b), .cmd(cmd), .ext_setpoint(ext_setpoint),
        .rsp_ff(rsp_ff), .bank_ff(bank_ff), .applied_setpoint_ff(applied_setpoint_ff),
        .ramp_time_ff(ramp_time_ff), .ramp_valid_ff(ramp_valid_ff));
    pmb_host host (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp_ff));

    // ****************************************************************
    // clock and hang guard
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // every entry reads back its reset value
    task automatic test_reset();
        for (int i = 0; i < pmb_pkg::NUM_REGS; i++) begin
            host.xfer(1'b0, pmb_pkg::REG_CODE[i], 16'h0000, ans);
            check_bit("read_valid", 1'b1, ans.valid);
            check_bit("read_err", 1'b0, ans.err);
            check_word("reset_value", pmb_pkg::REG_RST[i], ans.rdata);
        end
    endtask

    // read-only ceiling refuses writes; unmapped codes are refused too
    task automatic test_ceiling();
        host.xfer(1'b1, pmb_pkg::CODE_CEILING, 16'h1234, ans);
        check_bit("ceiling_write_err", 1'b1, ans.err);
        host.xfer(1'b0, pmb_pkg::CODE_CEILING, 16'h0000, ans);
        check_word("ceiling_value", 16'h7800, ans.rdata);
        check_word("ceiling_store", 16'h7800, bank_ff[pmb_pkg::IDX_CEILING]);
        host.xfer(1'b0, 8'h22, 16'h0000, ans);
        check_bit("unmapped_err", 1'b1, ans.err);
    endtask

    // every response code into every action byte, upper byte junk
    task automatic test_actions();
        logic [7:0] codes [5] = '{8'h41, 8'h47, 8'h50, 8'h56, 8'h5a};
        logic [3:0] ok [5] = '{4'b0100, 4'b1000, 4'b1000, 4'b1100, 4'b0101};
        logic [7:0] held [5] = '{8'hbf, 8'hff, 8'hc0, 8'hbf, 8'h00};
        logic [7:0] v;
        for (int r = 0; r < 5; r++) begin
            for (int c = 0; c < 4; c++) begin
                v = {c[1:0], 6'h2a};
                host.xfer(1'b1, codes[r], {8'h5a, v}, ans);
                check_bit("action_err", ~ok[r][c], ans.err);
                if (ok[r][c]) begin
                    held[r] = v;
                end
                host.xfer(1'b0, codes[r], 16'h0000, ans);
                check_word("action_value", {8'h00, held[r]}, ans.rdata);
            end
        end
    endtask

    // commanded set point applies only while the select is clear
    task automatic test_source();
        host.xfer(1'b1, pmb_pkg::CODE_SETPOINT, 16'h1234, ans);
        @(negedge sys_clk);
        check_word("applied", 16'h1234, applied_setpoint_ff);
        ext_setpoint = 16'h5678;
        host.xfer(1'b1, pmb_pkg::CODE_SRC_SEL, 16'h00ff, ans);
        host.xfer(1'b0, pmb_pkg::CODE_SRC_SEL, 16'h0000, ans);
        check_word("select_value", 16'h0001, ans.rdata);
        check_word("applied", 16'h5678, applied_setpoint_ff);
        host.xfer(1'b1, pmb_pkg::CODE_SETPOINT, 16'h4321, ans);
        @(negedge sys_clk);
        check_word("applied", 16'h5678, applied_setpoint_ff);
        host.xfer(1'b1, pmb_pkg::CODE_SRC_SEL, 16'h0000, ans);
        repeat (2) @(negedge sys_clk);
        check_word("applied", 16'h4321, applied_setpoint_ff);
    endtask

    // bounded wait for a settled ramp time
    task automatic wait_ramp();
        int n;
        n = 0;
        repeat (3) @(negedge sys_clk);
        while (ramp_valid_ff !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check_bit("ramp_valid", 1'b1, ramp_valid_ff);
    endtask

    // ramp scales with set point over the ceiling, exponent kept
    task automatic test_ramp();
        host.xfer(1'b1, 8'h61, 16'hf8c8, ans);
        host.xfer(1'b1, pmb_pkg::CODE_SETPOINT, 16'h3c00, ans);
        wait_ramp();
        check_word("ramp_half", 16'hf864, ramp_time_ff);
        host.xfer(1'b1, pmb_pkg::CODE_SETPOINT, 16'h7800, ans);
        wait_ramp();
        check_word("ramp_full", 16'hf8c8, ramp_time_ff);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        fails = 0;
        comparisons = 0;
        cycles = 0;
        rst_b = 1'b0;
        ext_setpoint = 16'h0000;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        test_reset();
        test_ceiling();
        test_actions();
        test_source();
        test_ramp();
        report_and_stop();
    end
endmodule
